// [design/eeprom_write_unlock_ctrl.sv]
// data eeprom controller with keyed, self-timed byte writes
// How it works
// R1 - software loads address and byte first
// R2 - keys 55h, AAh, then trigger, per byte
// R3 - wrong cycle spacing discards the write
// R4 - software masks interrupts during the sequence
// R5 - trigger ignored while permit is clear
// R6 - permit changes only by software write
// R7 - clearing permit never aborts running write
// R8 - on finish, trigger clears, done flag sets
// R9 - done flag sticky until software clears it
// R10 - software keeps permit clear when idle
// R11 - power-up clears the permit
// R12 - power-up timer blocks every write
// R13 - code protection never blocks or scrambles
// R14 - software verifies written bytes by readback
// R15 - read trigger loads byte next cycle; here a read trigger is ignored while a write is busy
// R16 - unlock port stores nothing, reads zero
// R17 - interrupt when flag, enable, global and peripheral enable set
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "nv_unlock_consts.svh"
module eeprom_write_unlock_ctrl #(
    parameter int AW          = 7,
    parameter int DEPTH       = 128,
    parameter int POWERUP_CYC = `POWERUP_CYC,
    parameter int WR_CYC      = `WRITE_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    output logic            irq
);
    localparam int          CW   = $clog2(WR_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(WR_CYC - 1);

    logic            rst_meta_ff;
    logic            rst_n;
    logic [7:0]      mem [0:DEPTH-1];
    logic [AW-1:0]   addr_ff;
    logic [AW-1:0]   nxt_addr;
    logic [7:0]      byte_ff;
    logic [7:0]      nxt_byte;
    logic            permit_ff;
    logic            nxt_permit;
    logic            busy_ff;
    logic            nxt_busy;
    logic [AW-1:0]   job_addr_ff;
    logic [AW-1:0]   nxt_job_addr;
    logic [7:0]      job_data_ff;
    logic [7:0]      nxt_job_data;
    logic [CW-1:0]   wcnt_ff;
    logic [CW-1:0]   nxt_wcnt;
    logic            flag_ff;
    logic            nxt_flag;
    logic            mask_ff;
    logic            nxt_mask;
    logic            global_en_ff;
    logic            nxt_global_en;
    logic            periph_en_ff;
    logic            nxt_periph_en;
    logic [7:0]      rdata_ff;
    logic [7:0]      nxt_rdata;
    logic            wr_addr;
    logic            wr_byte;
    logic            wr_ctrl;
    logic            wr_key;
    logic            wr_mask;
    logic            wr_glob;
    logic            rd_flag;
    logic            trig_wr;
    logic            rd_trig;
    logic            unlock_ok;
    logic            powerup_running;
    logic            start;
    logic            done;

    // ======================================================
    // reset release
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n       <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n       <= rst_meta_ff;
        end
    end

    // ======================================================
    // write decode
    assign wr_addr = reg_wr && reg_addr == `ADDR_REG;
    assign wr_byte = reg_wr && reg_addr == `BYTE_REG;
    assign wr_ctrl = reg_wr && reg_addr == `CTRL_REG;
    assign wr_key  = reg_wr && reg_addr == `KEY_PORT;
    assign wr_mask = reg_wr && reg_addr == `MASK_REG;
    assign wr_glob = reg_wr && reg_addr == `GLOB_REG;
    assign rd_flag = reg_rd && reg_addr == `FLAG_REG;
    assign trig_wr = wr_ctrl && reg_wdata[`CTRL_WR_BIT];
    assign rd_trig = wr_ctrl && reg_wdata[`CTRL_RD_BIT] && !busy_ff;

    // ======================================================
    // unlock sequence and power-up delay
    key_sequencer #(
        .GAP       (`KEY_GAP_CYC)
    ) u_keys (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .ce        (clk_en),
        .any_wr    (reg_wr),
        .key_wr    (wr_key), // [R16]
        .key_data  (reg_wdata),
        .trig_wr   (trig_wr),
        .unlock_ok (unlock_ok)
    );

    powerup_delay_timer #(
        .CYC     (POWERUP_CYC)
    ) u_powerup (
        .clk     (sys_clk),
        .rst_n   (rst_n),
        .ce      (clk_en),
        .running (powerup_running)
    );

    // ======================================================
    // write engine
    assign start = unlock_ok && permit_ff && !busy_ff // [R5]
                   && !powerup_running; // [R12]
    assign done  = busy_ff && wcnt_ff == LAST;

    always_comb begin
        nxt_addr     = addr_ff;
        nxt_byte     = byte_ff;
        nxt_permit   = permit_ff;
        nxt_busy     = busy_ff;
        nxt_job_addr = job_addr_ff;
        nxt_job_data = job_data_ff;
        nxt_wcnt     = wcnt_ff;
        if (wr_addr) begin
            nxt_addr = reg_wdata[AW-1:0]; // [R1]
        end
        if (wr_byte) begin
            nxt_byte = reg_wdata; // [R1] [R15]
        end else if (rd_trig) begin
            nxt_byte = mem[addr_ff]; // [R15] [R13]
        end
        if (wr_ctrl) begin
            nxt_permit = reg_wdata[`CTRL_PERMIT_BIT]; // [R6]
        end
        if (start) begin
            nxt_busy     = 1'b1; // [R2]
            nxt_job_addr = addr_ff; // [R1]
            nxt_job_data = byte_ff;
            nxt_wcnt     = '0;
        end else if (done) begin
            nxt_busy = 1'b0; // [R8]
        end else if (busy_ff) begin
            nxt_wcnt = wcnt_ff + CW'(1); // [R7]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff     <= '0;
            byte_ff     <= `RESET_BYTE;
            permit_ff   <= 1'b0; // [R11]
            busy_ff     <= 1'b0;
            job_addr_ff <= '0;
            job_data_ff <= `RESET_BYTE;
            wcnt_ff     <= '0;
        end else if (clk_en) begin
            addr_ff     <= nxt_addr;
            byte_ff     <= nxt_byte;
            permit_ff   <= nxt_permit;
            busy_ff     <= nxt_busy;
            job_addr_ff <= nxt_job_addr;
            job_data_ff <= nxt_job_data;
            wcnt_ff     <= nxt_wcnt;
        end
    end

    // cells are written unscrambled whatever the protection state
    always_ff @(posedge sys_clk) begin
        if (clk_en && rst_n && done) begin
            mem[job_addr_ff] <= job_data_ff; // [R7] [R13]
        end
    end

    // ======================================================
    // flags, interrupt and readback
    always_comb begin
        nxt_flag = flag_ff;
        nxt_mask = mask_ff;
        nxt_global_en = global_en_ff;
        nxt_periph_en = periph_en_ff;
        if (rd_flag) begin
            nxt_flag = 1'b0; // [R9]
        end
        if (done) begin
            nxt_flag = 1'b1; // [R8]
        end
        if (wr_mask) begin
            nxt_mask = reg_wdata[`DONE_BIT];
        end
        if (wr_glob) begin
            nxt_global_en = reg_wdata[`GLOBAL_EN_BIT];
            nxt_periph_en = reg_wdata[`PERIPH_EN_BIT];
        end
        nxt_rdata = 8'h00;
        if (!reg_rd) begin
            nxt_rdata = 8'h00;
        end else if (reg_addr == `ADDR_REG) begin
            nxt_rdata = 8'(addr_ff);
        end else if (reg_addr == `BYTE_REG) begin
            nxt_rdata = byte_ff;
        end else if (reg_addr == `CTRL_REG) begin
            nxt_rdata[`CTRL_PERMIT_BIT] = permit_ff;
            nxt_rdata[`CTRL_WR_BIT]     = busy_ff;
        end else if (reg_addr == `KEY_PORT) begin
            nxt_rdata = 8'h00; // [R16]
        end else if (reg_addr == `FLAG_REG) begin
            nxt_rdata[`DONE_BIT] = flag_ff;
        end else if (reg_addr == `MASK_REG) begin
            nxt_rdata[`DONE_BIT] = mask_ff;
        end else if (reg_addr == `GLOB_REG) begin
            nxt_rdata[`GLOBAL_EN_BIT] = global_en_ff;
            nxt_rdata[`PERIPH_EN_BIT] = periph_en_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff  <= 1'b0;
            mask_ff  <= 1'b0;
            global_en_ff <= 1'b0;
            periph_en_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else if (clk_en) begin
            flag_ff  <= nxt_flag;
            mask_ff  <= nxt_mask;
            global_en_ff <= nxt_global_en;
            periph_en_ff <= nxt_periph_en;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign irq       = flag_ff && mask_ff // [R17]
                       && global_en_ff && periph_en_ff;

    // ======================================================
    // checks
    sequence key_one_s;
        clk_en && wr_key && reg_wdata == `KEY_FIRST;
    endsequence

    sequence key_two_s;
        clk_en && wr_key && reg_wdata == `KEY_SECOND;
    endsequence

    sequence unlock_s;
        key_one_s ##2 key_two_s ##2 (clk_en && trig_wr);
    endsequence

    property unlock_starts_p;
        @(posedge sys_clk) disable iff (!rst_n)
        unlock_s ##0 (permit_ff && !busy_ff && !powerup_running)
        |=> busy_ff && job_addr_ff == $past(addr_ff);
    endproperty

    key_unlock_a: assert property (unlock_starts_p) // [R2]
        else $error("valid unlock did not start write");

    start_cause_a: assert property (@(posedge sys_clk) // [R2]
        disable iff (!rst_n) $rose(busy_ff) |-> $past(unlock_ok))
        else $error("write started without unlock");

    permit_block_a: assert property (@(posedge sys_clk) // [R5]
        disable iff (!rst_n) clk_en && !busy_ff && !permit_ff
        |=> !busy_ff)
        else $error("write started without permit");

    permit_source_a: assert property (@(posedge sys_clk) // [R6]
        disable iff (!rst_n) $changed(permit_ff) |-> $past(wr_ctrl))
        else $error("permit changed without software write");

    run_on_a: assert property (@(posedge sys_clk) // [R7]
        disable iff (!rst_n) busy_ff && !done && wcnt_ff < LAST
        |=> busy_ff)
        else $error("running write aborted");

    finish_flag_a: assert property (@(posedge sys_clk) // [R8]
        disable iff (!rst_n) clk_en && done
        |=> !busy_ff && flag_ff && mem[$past(job_addr_ff)]
            == $past(job_data_ff))
        else $error("write finish not signalled");

    flag_hold_a: assert property (@(posedge sys_clk) // [R9]
        disable iff (!rst_n) flag_ff && !rd_flag |=> flag_ff)
        else $error("done flag lost without software");

    permit_reset_a: assert property (@(posedge sys_clk) // [R11]
        $rose(rst_n) |-> !permit_ff)
        else $error("permit set after power-up");

    powerup_block_a: assert property (@(posedge sys_clk) // [R12]
        disable iff (!rst_n) powerup_running && !busy_ff |=> !busy_ff)
        else $error("write during power-up delay");

    read_next_a: assert property (@(posedge sys_clk) // [R15]
        disable iff (!rst_n) clk_en && rd_trig
        |=> byte_ff == $past(mem[addr_ff]))
        else $error("read data not loaded next cycle");

    key_read_a: assert property (@(posedge sys_clk) // [R16]
        disable iff (!rst_n) clk_en && reg_rd && reg_addr == `KEY_PORT
        |=> reg_rdata == 8'h00)
        else $error("unlock port read not zero");

    irq_level_a: assert property (@(posedge sys_clk) // [R17]
        disable iff (!rst_n) clk_en && done && mask_ff && global_en_ff
        && periph_en_ff && !wr_mask && !wr_glob |=> irq)
        else $error("interrupt not raised on finish");
endmodule

// [design/nv_unlock_consts.svh]
// constants for the data eeprom write controller
`ifndef NV_UNLOCK_CONSTS_SVH
`define NV_UNLOCK_CONSTS_SVH
// ==========================================================
// register offsets
`define ADDR_REG 3'h0
`define BYTE_REG 3'h1
`define CTRL_REG 3'h2
`define KEY_PORT 3'h3
`define FLAG_REG 3'h4
`define MASK_REG 3'h5
`define GLOB_REG 3'h6
// ==========================================================
// field positions
`define CTRL_RD_BIT     0
`define CTRL_WR_BIT     1
`define CTRL_PERMIT_BIT 2
`define DONE_BIT        7
`define GLOBAL_EN_BIT   7
`define PERIPH_EN_BIT   6
// ==========================================================
// reset values and keys
`define RESET_BYTE  8'h00
`define KEY_FIRST   8'h55
`define KEY_SECOND  8'haa
// ==========================================================
// timing
`define KEY_GAP_CYC   2
`define WRITE_CYC     100
`define POWERUP_MS    72
`define CLK_FREQ_KHZ  50000
`define POWERUP_CYC   (`POWERUP_MS * `CLK_FREQ_KHZ)
`endif

// [design/nv_unlock_pkg.sv]
// types for the data eeprom write controller
package nv_unlock_pkg;
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_KEY1 = 3'b010,
        SEQ_KEY2 = 3'b100
    } seq_state_t;
endpackage

// [design/key_sequencer.sv]
// two-key unlock detector with exact cycle spacing
`timescale 1ns/1ps
`include "nv_unlock_consts.svh"
module key_sequencer #(
    parameter int GAP = `KEY_GAP_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       any_wr,
    input  wire logic       key_wr,
    input  wire logic [7:0] key_data,
    input  wire logic       trig_wr,
    output logic            unlock_ok
);
    localparam logic [3:0] STEP = 4'(GAP - 1);

    nv_unlock_pkg::seq_state_t state_ff;
    nv_unlock_pkg::seq_state_t nxt_state;
    logic [3:0]                cnt_ff;
    logic [3:0]                nxt_cnt;
    logic                      first_key;
    logic                      on_time;

    // ======================================================
    // sequence tracking
    always_comb begin
        first_key = key_wr && (key_data == `KEY_FIRST);
        on_time   = (cnt_ff == STEP);
        nxt_state = state_ff;
        nxt_cnt   = (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
        unlock_ok = 1'b0;
        case (state_ff)
            nv_unlock_pkg::SEQ_KEY1: begin
                if (key_wr && key_data == `KEY_SECOND && on_time) begin
                    nxt_state = nv_unlock_pkg::SEQ_KEY2; // [R2] [R3]
                    nxt_cnt   = 4'h0;
                end else if (first_key) begin
                    nxt_cnt   = 4'h0;
                end else if (any_wr || cnt_ff >= STEP) begin
                    nxt_state = nv_unlock_pkg::SEQ_IDLE; // [R3]
                end
            end
            nv_unlock_pkg::SEQ_KEY2: begin
                if (trig_wr && on_time) begin
                    unlock_ok = 1'b1; // [R2] [R3]
                    nxt_state = nv_unlock_pkg::SEQ_IDLE;
                end else if (first_key) begin
                    nxt_state = nv_unlock_pkg::SEQ_KEY1;
                    nxt_cnt   = 4'h0;
                end else if (any_wr || cnt_ff >= STEP) begin
                    nxt_state = nv_unlock_pkg::SEQ_IDLE; // [R3]
                end
            end
            default: begin
                if (first_key) begin
                    nxt_state = nv_unlock_pkg::SEQ_KEY1;
                    nxt_cnt   = 4'h0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= nv_unlock_pkg::SEQ_IDLE;
            cnt_ff   <= 4'h0;
        end else if (ce) begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ======================================================
    // checks
    late_key_a: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
        ce && state_ff == nv_unlock_pkg::SEQ_KEY1 && !on_time && key_wr
        && key_data == `KEY_SECOND |=> state_ff != nv_unlock_pkg::SEQ_KEY2)
        else $error("second key off time accepted");
endmodule

// [design/powerup_delay_timer.sv]
// power-up delay timer, counts down once after reset
`timescale 1ns/1ps
`include "nv_unlock_consts.svh"
module powerup_delay_timer #(
    parameter int CYC = `POWERUP_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    output logic      running
);
    localparam int W = $clog2(CYC + 1);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;

    // ======================================================
    // countdown
    always_comb begin
        nxt_cnt = (cnt_ff != '0) ? cnt_ff - W'(1) : cnt_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= W'(CYC);
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign running = (cnt_ff != '0); // [R12]
endmodule

// [testbench/eeprom_write_unlock_ctrl_bench.sv]
// self-checking bench for the data eeprom write controller
`timescale 1ns/1ps
`include "nv_unlock_consts.svh"
module eeprom_write_unlock_ctrl_bench;
    // ==========================================================
    // signals
    localparam int PW = 40;
    localparam int WC = 8;
    logic       sys_clk;
    logic       arst_n;
    logic       clk_en;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       irq;
    logic [7:0] mem_model [0:127];
    logic [7:0] rv;
    int         mismatches;
    int         samples_checked;

    eeprom_write_unlock_ctrl #(
        .POWERUP_CYC (PW),
        .WR_CYC      (WC)
    ) dut (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .clk_en    (clk_en),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .irq       (irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // expectations and compares
    function automatic logic [7:0] ctrl_exp(input logic permit,
                                            input logic busy);
        return {5'h00, permit, busy, 1'b0};
    endfunction

    function automatic logic [7:0] flag_exp(input logic done);
        return {done, 7'h00};
    endfunction

    function automatic logic [6:0] addr_of(input int i);
        return (i == 7) ? 7'h7f : 7'(i) * 7'h12;
    endfunction

    task automatic conclude();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp,
                        input logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask

    // ==========================================================
    // register bus cycles
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        rd(`CTRL_REG, rv);
        while (rv[`CTRL_WR_BIT] !== 1'b0) begin
            n++;
            if (n > 40) begin
                mismatches++;
                $display("CHECK FAILED busy expected 0 seen %b", rv[1]);
                conclude();
            end
            rd(`CTRL_REG, rv);
        end
    endtask

    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(`CTRL_REG, rv);
        chk8("ctrl_reset", 8'h00, rv);
    endtask

    // ==========================================================
    // one write attempt, faults: 1 key, 2 spacing, 3 permit, 4 order
    task automatic attempt(input logic [6:0] a, input logic [7:0] d,
                           input int fault, input bit live,
                           input bit men);
        bit         good;
        bit         drop;
        logic [7:0] m;
        good = (fault == 0) && live;
        drop = 1'($urandom);
        m = live ? 8'h06 : 8'h02;
        wr(`ADDR_REG, {1'b0, a});
        wr(`BYTE_REG, d);
        wr(`MASK_REG, {men, 7'h00});
        wr(`GLOB_REG, 8'h00);
        wr(`CTRL_REG, (fault == 3) ? 8'h00 : 8'h04);
        wr(`KEY_PORT, (fault == 4) ? `KEY_SECOND : `KEY_FIRST);
        if (fault == 2) begin
            @(posedge sys_clk);
        end
        wr(`KEY_PORT, (fault == 1) ? 8'h5a :
                      (fault == 4) ? `KEY_FIRST : `KEY_SECOND);
        wr(`CTRL_REG, (fault == 3) ? 8'h02 : 8'h06);
        wr(`GLOB_REG, 8'hc0);
        // frozen cycles must not count toward the write
        @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (10) @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(`CTRL_REG, rv);
        chk8("busy", ctrl_exp(fault != 3, good) & m, rv & m);
        if (good && drop) begin
            wr(`CTRL_REG, 8'h00);
        end
        wait_idle();
        chk8("permit", ctrl_exp((fault != 3) && !(good && drop), 1'b0) & m,
             rv & m);
        if (good) begin
            mem_model[a] = d;
        end
        repeat ($urandom_range(0, 7)) @(posedge sys_clk);
        #1;
        chk1("irq", good & men, irq);
        rd(`FLAG_REG, rv);
        chk8("flag", flag_exp(good), rv);
        chk1("irq_clear", 1'b0, irq);
        wr(`CTRL_REG, 8'h01);
        rd(`BYTE_REG, rv);
        chk8("readback", mem_model[a], rv);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        void'($urandom(92433));
        do_reset();
        repeat (PW + 10) @(posedge sys_clk);
        wr(`GLOB_REG, 8'hc0);
        for (int i = 0; i < 8; i++) begin
            attempt(addr_of(i), 8'($urandom), 0, 1'b1, i[0]);
        end
        wr(`KEY_PORT, `KEY_FIRST);
        rd(`KEY_PORT, rv);
        chk8("key_port", 8'h00, rv);
        wr(3'h7, 8'hff);
        rd(3'h7, rv);
        chk8("unmapped", 8'h00, rv);
        @(posedge sys_clk);
        #1;
        chk8("rdata_idle", 8'h00, reg_rdata);
        for (int i = 0; i < 40; i++) begin
            attempt(addr_of($urandom_range(0, 7)), 8'($urandom),
                    $urandom_range(0, 4), 1'b1, 1'($urandom));
        end
        do_reset();
        attempt(addr_of(0), ~mem_model[addr_of(0)], 0, 1'b0,
                1'b1);
        conclude();
    end

    initial begin
        #1000000;
        mismatches++;
        $display("CHECK FAILED run expected done seen hang");
        conclude();
    end
endmodule
